// >>> include/pnp_config_pkg.sv
package pnp_config_pkg;

  typedef enum logic [1:0] {
    jumper_mode,
    vendor_jumperless_mode,
    plug_play_mode
  } config_mode_t;

  typedef enum logic {
    wait_for_key,
    config_open
  } key_state_t;

  // Register indices on the configuration address port
  localparam logic [7:0] IDX_SELECT_NUMBER    = 8'h06;
  localparam logic [7:0] IDX_ACTIVATE         = 8'h30;
  localparam logic [7:0] IDX_ROM_BASE_HIGH    = 8'h40;
  localparam logic [7:0] IDX_ROM_BASE_LOW     = 8'h41;
  localparam logic [7:0] IDX_MEMORY_CONTROL   = 8'h42;
  localparam logic [7:0] IDX_IO_BASE_HIGH     = 8'h60;
  localparam logic [7:0] IDX_IO_BASE_LOW      = 8'h61;
  localparam logic [7:0] IDX_IRQ_LEVEL        = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE         = 8'h71;
  localparam logic [7:0] IDX_DMA_SELECT_ZERO  = 8'h74;
  localparam logic [7:0] IDX_DMA_SELECT_ONE   = 8'h75;
  localparam logic [7:0] IDX_CONFIG_ZERO      = 8'hF0;
  localparam logic [7:0] IDX_CONFIG_ONE       = 8'hF1;
  localparam logic [7:0] IDX_CONFIG_TWO       = 8'hF2;
  localparam logic [7:0] IDX_CONFIG_THREE     = 8'hF3;
  localparam logic [7:0] IDX_SAVED_SELECT     = 8'hF5;
  localparam logic [7:0] IDX_VENDOR_COMMAND   = 8'hF6;

  // Writable bit masks, every other bit is fixed at zero
  localparam logic [7:0] MASK_ROM_BASE_HIGH   = 8'h0D;
  localparam logic [7:0] MASK_ROM_BASE_LOW    = 8'hC0;
  localparam logic [7:0] MASK_IO_BASE_HIGH    = 8'h03;
  localparam logic [7:0] MASK_IO_BASE_LOW     = 8'hE0;
  localparam logic [7:0] MASK_IRQ_LEVEL       = 8'h0F;
  localparam logic [7:0] MASK_ACTIVATE        = 8'h01;

  // Fixed read values
  localparam logic [7:0] VALUE_MEMORY_CONTROL = 8'h00;
  localparam logic [7:0] VALUE_IRQ_TYPE       = 8'h02;
  localparam logic [7:0] VALUE_DMA_SELECT     = 8'h04;
  localparam logic [7:0] VALUE_ZERO           = 8'h00;

  localparam int VENDOR_RESET_SELECT_BIT = 2;

  // Vendor configuration mirror field positions
  localparam int CFG0_JUMPER_BIT     = 3;
  localparam int CFG0_PLUG_PLAY_BIT  = 2;
  localparam int CFG3_PLUG_PLAY_BIT  = 7;
  localparam int CFG3_INACTIVE_BIT   = 0;

  localparam int KEY_LENGTH = 32;
  localparam logic [4:0] KEY_LAST = 5'h1F;

  localparam logic [1:0][0:31][7:0] KEY_TABLE = '{
    '{8'h6A, 8'hB5, 8'hDA, 8'hED, 8'hF6, 8'hFB, 8'h7D, 8'hBE,
      8'hDF, 8'h6F, 8'h37, 8'h1B, 8'h0D, 8'h86, 8'hC3, 8'h61,
      8'hB0, 8'h58, 8'h2C, 8'h16, 8'h8B, 8'h45, 8'hA2, 8'hD1,
      8'hE8, 8'h74, 8'h3A, 8'h9D, 8'hCE, 8'hE7, 8'h73, 8'h39},
    '{8'hDA, 8'h6D, 8'h36, 8'h1B, 8'h8D, 8'h46, 8'h23, 8'h91,
      8'h48, 8'hA4, 8'hD2, 8'h69, 8'h34, 8'h9A, 8'h4D, 8'h26,
      8'h13, 8'h89, 8'h44, 8'hA2, 8'h51, 8'h28, 8'h94, 8'hCA,
      8'h65, 8'h32, 8'h19, 8'h0C, 8'h86, 8'h43, 8'hA1, 8'h50}
  };
  localparam int PLUG_PLAY_KEY = 1;
  localparam int VENDOR_KEY    = 0;

endpackage : pnp_config_pkg

// >>> src/pnp_logical_device_config.sv
`timescale 1ns/10ps
`default_nettype none

module pnp_logical_device_config (
  input  wire logic                        i_clock,
  input  wire logic                        i_reset,
  input  wire logic                        i_address_write,
  input  wire logic                        i_data_write,
  input  wire logic                        i_data_read,
  input  wire logic [7:0]                  i_write_data,
  input  wire logic                        i_jumper_strap,
  input  wire logic                        i_plug_play_strap,
  input  wire logic [15:0]                 i_jumper_io_base,
  input  wire logic [3:0]                  i_jumper_irq_level,
  input  wire logic [15:0]                 i_jumper_rom_base,
  input  wire logic                        i_eeprom_plug_play,
  input  wire logic                        i_eeprom_inactive_at_powerup_n,
  input  wire logic [15:0]                 i_eeprom_io_base,
  input  wire logic [3:0]                  i_eeprom_irq_level,
  input  wire logic [15:0]                 i_eeprom_rom_base,
  input  wire logic [4:0]                  i_eeprom_rom_size,
  input  wire logic                        i_eeprom_load,
  output logic      [7:0]                  o_read_data,
  output pnp_config_pkg::config_mode_t     o_config_mode,
  output logic                             o_config_open,
  output logic                             o_device_active,
  output logic      [15:0]                 o_io_base,
  output logic      [3:0]                  o_irq_level,
  output logic      [23:0]                 o_boot_rom_base,
  output logic      [4:0]                  o_boot_rom_size,
  output logic      [7:0]                  o_card_select_number
);
  import pnp_config_pkg::*;

  config_mode_t mode_next;
  config_mode_t mode_reg;
  key_state_t   key_state_reg;
  logic         restore;
  logic         power_up_active;
  logic [7:0]   index_reg;
  logic [7:0]   rom_base_high_reg;
  logic [7:0]   rom_base_low_reg;
  logic [7:0]   io_base_high_reg;
  logic [7:0]   io_base_low_reg;
  logic [7:0]   irq_level_reg;
  logic [7:0]   activate_reg;
  logic [4:0]   rom_size_reg;
  logic [7:0]   select_number_reg;
  logic [7:0]   saved_select_reg;
  logic [7:0]   config_zero;
  logic [7:0]   config_one;
  logic [7:0]   config_two;
  logic [7:0]   config_three;
  logic [7:0]   read_next;
  logic [15:0]  source_io_base;
  logic [15:0]  source_rom_base;
  logic [3:0]   source_irq_level;
  logic [1:0]   key_done;
  logic         key_accept;
  logic         reg_write;
  logic         vendor_reset_select;

  // Straps are live levels; mode follows them every cycle
  always_comb begin
    if (i_jumper_strap) begin
      mode_next = jumper_mode;
    end else if (i_plug_play_strap || i_eeprom_plug_play) begin
      mode_next = plug_play_mode;
    end else begin
      mode_next = vendor_jumperless_mode;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_reg <= jumper_mode;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign restore = i_reset || i_eeprom_load;

  always_comb begin
    if (mode_next == jumper_mode) begin
      source_io_base   = i_jumper_io_base;
      source_rom_base  = i_jumper_rom_base;
      source_irq_level = i_jumper_irq_level;
    end else begin
      source_io_base   = i_eeprom_io_base;
      source_rom_base  = i_eeprom_rom_base;
      source_irq_level = i_eeprom_irq_level;
    end
  end

  // Only plug-play mode honours the EEPROM inactive bit
  assign power_up_active = (mode_next == plug_play_mode) ?
                           !i_eeprom_inactive_at_powerup_n : 1'b1;

  // Key matchers, one per key, restart on any mismatch
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : key_match
      logic [4:0] count_reg;
      assign key_done[k] = i_address_write &&
                           (key_state_reg == wait_for_key) &&
                           (count_reg == KEY_LAST) &&
                           (i_write_data == KEY_TABLE[k][KEY_LAST]);
      always_ff @(posedge i_clock) begin
        if (i_reset || key_state_reg != wait_for_key) begin
          count_reg <= 5'h00;
        end else if (i_address_write) begin
          if (i_write_data == KEY_TABLE[k][count_reg]) begin
            count_reg <= count_reg + 5'h01;
          end else if (i_write_data == KEY_TABLE[k][0]) begin
            count_reg <= 5'h01;
          end else begin
            count_reg <= 5'h00;
          end
        end
      end
    end
  endgenerate

  // Standard key only counts once plug-play mode is latched
  assign key_accept = key_done[VENDOR_KEY] ||
                      (key_done[PLUG_PLAY_KEY] &&
                       mode_reg == plug_play_mode);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      key_state_reg <= wait_for_key;
    end else if (key_accept) begin
      key_state_reg <= config_open;
    end
  end

  // Index only moves once configuration is open, else bytes are key
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      index_reg <= VALUE_ZERO;
    end else if (i_address_write && key_state_reg == config_open) begin
      index_reg <= i_write_data;
    end
  end

  assign reg_write = i_data_write && key_state_reg == config_open;
  assign vendor_reset_select = reg_write &&
                               index_reg == IDX_VENDOR_COMMAND &&
                               i_write_data[VENDOR_RESET_SELECT_BIT];

  // Resource registers; read-only bits never store anything
  always_ff @(posedge i_clock) begin
    if (restore) begin
      rom_base_high_reg <= source_rom_base[15:8] & MASK_ROM_BASE_HIGH;
      rom_base_low_reg  <= source_rom_base[7:0] & MASK_ROM_BASE_LOW;
      io_base_high_reg  <= source_io_base[15:8] & MASK_IO_BASE_HIGH;
      io_base_low_reg   <= source_io_base[7:0] & MASK_IO_BASE_LOW;
      irq_level_reg     <= {4'h0, source_irq_level};
    end else if (reg_write) begin
      unique case (index_reg)
        IDX_ROM_BASE_HIGH:
          rom_base_high_reg <= i_write_data & MASK_ROM_BASE_HIGH;
        IDX_ROM_BASE_LOW:
          rom_base_low_reg <= i_write_data & MASK_ROM_BASE_LOW;
        IDX_IO_BASE_HIGH:
          io_base_high_reg <= i_write_data & MASK_IO_BASE_HIGH;
        IDX_IO_BASE_LOW:
          io_base_low_reg <= i_write_data & MASK_IO_BASE_LOW;
        IDX_IRQ_LEVEL:
          irq_level_reg <= i_write_data & MASK_IRQ_LEVEL;
        default: begin
          // Read-only and unknown indices drop the write
        end
      endcase
    end
  end

  // Size has no software path at all
  always_ff @(posedge i_clock) begin
    if (restore) begin
      rom_size_reg <= i_eeprom_rom_size;
    end
  end

  // Restore overrides software; otherwise writes always win
  always_ff @(posedge i_clock) begin
    if (restore) begin
      activate_reg <= {7'h00, power_up_active};
    end else if (reg_write && index_reg == IDX_ACTIVATE) begin
      activate_reg <= i_write_data & MASK_ACTIVATE;
    end
  end

  // Select number survives auto-load; bus reset or the vendor reset-select command clears it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      select_number_reg <= VALUE_ZERO;
    end else if (vendor_reset_select) begin
      select_number_reg <= VALUE_ZERO;
    end else if (reg_write && index_reg == IDX_SELECT_NUMBER) begin
      select_number_reg <= i_write_data;
    end
  end

  // Saved copy ignores the vendor clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      saved_select_reg <= VALUE_ZERO;
    end else if (reg_write && index_reg == IDX_SELECT_NUMBER) begin
      saved_select_reg <= i_write_data;
    end
  end

  // Vendor copies are live views of the strap inputs, mode and resource state
  always_comb begin
    config_zero = VALUE_ZERO;
    config_zero[CFG0_JUMPER_BIT]    = i_jumper_strap;
    config_zero[CFG0_PLUG_PLAY_BIT] = i_plug_play_strap;
    config_one   = {io_base_high_reg[1:0], io_base_low_reg[7:5],
                    irq_level_reg[2:0]};
    config_two   = {3'h0, rom_size_reg};
    config_three = VALUE_ZERO;
    config_three[CFG3_PLUG_PLAY_BIT] = (mode_reg == plug_play_mode);
    config_three[CFG3_INACTIVE_BIT]  = (mode_reg == plug_play_mode) &&
                                       i_eeprom_inactive_at_powerup_n;
  end

  always_comb begin
    unique case (index_reg)
      IDX_SELECT_NUMBER:   read_next = select_number_reg;
      IDX_ACTIVATE:        read_next = activate_reg;
      IDX_ROM_BASE_HIGH:   read_next = rom_base_high_reg;
      IDX_ROM_BASE_LOW:    read_next = rom_base_low_reg;
      IDX_MEMORY_CONTROL:  read_next = VALUE_MEMORY_CONTROL;
      IDX_IO_BASE_HIGH:    read_next = io_base_high_reg;
      IDX_IO_BASE_LOW:     read_next = io_base_low_reg;
      IDX_IRQ_LEVEL:       read_next = irq_level_reg;
      IDX_IRQ_TYPE:        read_next = VALUE_IRQ_TYPE;
      IDX_DMA_SELECT_ZERO: read_next = VALUE_DMA_SELECT;
      IDX_DMA_SELECT_ONE:  read_next = VALUE_DMA_SELECT;
      IDX_CONFIG_ZERO:     read_next = config_zero;
      IDX_CONFIG_ONE:      read_next = config_one;
      IDX_CONFIG_TWO:      read_next = config_two;
      IDX_CONFIG_THREE:    read_next = config_three;
      IDX_SAVED_SELECT:    read_next = saved_select_reg;
      // Command bit is a pulse, never stored
      default:             read_next = VALUE_ZERO;
    endcase
  end

  // Closed port reads zero so a probe before the key sees nothing
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_read_data <= VALUE_ZERO;
    end else if (i_data_read) begin
      o_read_data <= (key_state_reg == config_open) ? read_next : VALUE_ZERO;
    end
  end

  assign o_config_mode        = mode_reg;
  assign o_config_open        = (key_state_reg == config_open);
  assign o_device_active      = activate_reg[0];
  assign o_io_base            = {io_base_high_reg, io_base_low_reg};
  assign o_irq_level          = irq_level_reg[3:0];
  assign o_boot_rom_base      = {rom_base_high_reg, rom_base_low_reg, 8'h00};
  assign o_boot_rom_size      = rom_size_reg;
  assign o_card_select_number = select_number_reg;

endmodule : pnp_logical_device_config

`default_nettype wire

// >>> tb/pnp_config_props.sv
`timescale 1ns/10ps
`default_nettype none
module pnp_config_props
  import pnp_config_pkg::*;
(
  input wire logic                         i_clock,
  input wire logic                         i_reset,
  input wire logic                         i_address_write,
  input wire logic                         i_data_write,
  input wire logic                         i_data_read,
  input wire logic [7:0]                   i_write_data,
  input wire logic                         i_jumper_strap,
  input wire logic                         i_plug_play_strap,
  input wire logic                         i_eeprom_plug_play,
  input wire logic [7:0]                   o_read_data,
  input wire pnp_config_pkg::config_mode_t o_config_mode,
  input wire logic                         o_config_open,
  input wire logic                         o_device_active,
  input wire logic [15:0]                  o_io_base,
  input wire logic [3:0]                   o_irq_level,
  input wire logic [7:0]                   o_card_select_number
);
  logic [7:0] index_reg;
  logic       wr;
  assign wr = i_data_write && o_config_open;
  // Index is tracked here because the design does not export it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      index_reg <= 8'h00;
    end else if (i_address_write && o_config_open) begin
      index_reg <= i_write_data;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  closed_read_zero_a: assert property (i_data_read && !o_config_open |=>
    o_read_data == 8'h00) else $error("closed read not zero");
  mode_jumper_a: assert property (i_jumper_strap |=>
    o_config_mode == jumper_mode) else $error("jumper mode wrong");
  mode_plug_a: assert property (!i_jumper_strap && (i_plug_play_strap ||
    i_eeprom_plug_play) |=> o_config_mode == plug_play_mode)
    else $error("plug play mode wrong");
  mode_vendor_a: assert property (!i_jumper_strap && !i_plug_play_strap &&
    !i_eeprom_plug_play |=> o_config_mode == vendor_jumperless_mode)
    else $error("vendor mode wrong");
  select_clear_a: assert property (wr && index_reg == IDX_VENDOR_COMMAND &&
    i_write_data[2] |=> o_card_select_number == 8'h00)
    else $error("select number not cleared");
  select_write_a: assert property (wr && index_reg == IDX_SELECT_NUMBER |=>
    o_card_select_number == $past(i_write_data)) else $error("select write");
  irq_write_a: assert property (wr && index_reg == IDX_IRQ_LEVEL |=>
    o_irq_level == $past(i_write_data[3:0])) else $error("irq level write");
  activate_write_a: assert property (wr && index_reg == IDX_ACTIVATE |=>
    o_device_active == $past(i_write_data[0])) else $error("activate write");
  io_low_write_a: assert property (wr && index_reg == IDX_IO_BASE_LOW |=>
    o_io_base[7:0] == ($past(i_write_data) & 8'hE0)) else $error("io low write");
  irq_type_read_a: assert property (o_config_open && i_data_read &&
    index_reg == IDX_IRQ_TYPE |=> o_read_data == 8'h02) else $error("irq type");
  dma_read_a: assert property (o_config_open && i_data_read &&
    index_reg[7:1] == 7'h3A |=> o_read_data == 8'h04) else $error("dma read");
endmodule : pnp_config_props
bind pnp_logical_device_config pnp_config_props i_props (.i_clock, .i_reset,
  .i_address_write, .i_data_write, .i_data_read, .i_write_data,
  .i_jumper_strap, .i_plug_play_strap, .i_eeprom_plug_play, .o_read_data,
  .o_config_mode, .o_config_open, .o_device_active, .o_io_base, .o_irq_level,
  .o_card_select_number);
`default_nettype wire

// >>> tb/pnp_isa_host.sv
`timescale 1ns/10ps
`default_nettype none
module pnp_isa_host
  import pnp_config_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic [7:0] i_read_data,
  output logic            o_address_write,
  output logic            o_data_write,
  output logic            o_data_read,
  output logic      [7:0] o_write_data
);
  initial begin
    {o_address_write, o_data_write, o_data_read} = 3'b000;
    o_write_data = 8'h00;
  end
  // Kind 0 address, 1 data write, 2 data read; one idle cycle between
  task automatic strobe(input int kind, input logic [7:0] data);
    @(negedge i_clock);
    o_write_data = data;
    {o_address_write, o_data_write, o_data_read} = {kind == 0, kind == 1,
                                                    kind == 2};
    @(negedge i_clock);
    {o_address_write, o_data_write, o_data_read} = 3'b000;
    o_write_data = ~data;
  endtask : strobe
  task automatic write_reg(input logic [7:0] index, input logic [7:0] data);
    strobe(0, index);
    strobe(1, data);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] index, output logic [7:0] data);
    strobe(0, index);
    strobe(2, 8'h00);
    data = i_read_data;
  endtask : read_reg
  // Byte at bad_at is spoiled to force the match to restart
  task automatic send_key(input int which, input int bad_at);
    for (int i = 0; i < KEY_LENGTH; i++) begin
      strobe(0, (i == bad_at) ? 8'h00 : KEY_TABLE[which][i]);
    end
  endtask : send_key
endmodule : pnp_isa_host
`default_nettype wire

// >>> tb/pnp_logical_device_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module pnp_logical_device_config_tb;
  import pnp_config_pkg::*;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         address_write, data_write, data_read, eeprom_load = 1'b0;
  logic         jumper_strap = 1'b1, plug_play_strap = 1'b1;
  logic         eeprom_plug_play = 1'b0, eeprom_inactive_n = 1'b1;
  logic  [7:0]  write_data, read_data, card;
  logic  [15:0] eeprom_io_base = 16'h0240;
  logic  [3:0]  eeprom_irq = 4'hA, irq_level;
  config_mode_t mode;
  logic         config_open, active;
  logic  [15:0] io_base;
  logic  [23:0] rom_base;
  logic  [4:0]  rom_size;
  int           miscompares = 0, total_checks = 0, cycles = 0;
  always #2 clock = ~clock;
  pnp_isa_host i_host (.i_clock(clock), .i_read_data(read_data),
    .o_address_write(address_write), .o_data_write(data_write),
    .o_data_read(data_read), .o_write_data(write_data));
  pnp_logical_device_config i_dut (.i_clock(clock), .i_reset(reset),
    .i_address_write(address_write), .i_data_write(data_write),
    .i_data_read(data_read), .i_write_data(write_data),
    .i_jumper_strap(jumper_strap), .i_plug_play_strap(plug_play_strap),
    .i_jumper_io_base(16'h0300), .i_jumper_irq_level(4'h3),
    .i_jumper_rom_base(16'h0DC0), .i_eeprom_plug_play(eeprom_plug_play),
    .i_eeprom_inactive_at_powerup_n(eeprom_inactive_n),
    .i_eeprom_io_base(eeprom_io_base), .i_eeprom_irq_level(eeprom_irq),
    .i_eeprom_rom_base(16'h0940), .i_eeprom_rom_size(5'h10),
    .i_eeprom_load(eeprom_load), .o_read_data(read_data),
    .o_config_mode(mode), .o_config_open(config_open),
    .o_device_active(active), .o_io_base(io_base), .o_irq_level(irq_level),
    .o_boot_rom_base(rom_base), .o_boot_rom_size(rom_size),
    .o_card_select_number(card));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic power(input logic jp, input logic pp, input logic ep);
    @(negedge clock);
    {jumper_strap, plug_play_strap, eeprom_plug_play} = {jp, pp, ep};
    reset = 1'b1;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
  endtask : power
  task automatic expect_reg(input logic [7:0] index, input logic [7:0] exp);
    logic [7:0] got;
    i_host.read_reg(index, got);
    `CHECK(got, exp)
  endtask : expect_reg
  task automatic jumper_keys();
    `CHECK(mode, jumper_mode)
    `CHECK(io_base, 16'h0300)
    `CHECK(rom_base, 24'h0DC000)
    `CHECK(active, 1'b1)
    i_host.send_key(PLUG_PLAY_KEY, 99);
    `CHECK(config_open, 1'b0)
    expect_reg(IDX_IRQ_LEVEL, 8'h00);
    i_host.send_key(VENDOR_KEY, 99);
    `CHECK(config_open, 1'b1)
    expect_reg(IDX_CONFIG_ZERO, 8'h0C);
    expect_reg(IDX_CONFIG_THREE, 8'h00);
    $display("jumper_keys done");
  endtask : jumper_keys
  task automatic masked_writes();
    logic [7:0] idx [8] = '{8'h40, 8'h41, 8'h42, 8'h60, 8'h61, 8'h71, 8'h74,
                            8'h75};
    logic [7:0] exp [8] = '{8'h0D, 8'hC0, 8'h00, 8'h03, 8'hE0, 8'h02, 8'h04,
                            8'h04};
    for (int i = 0; i < 8; i++) begin
      i_host.write_reg(idx[i], 8'hFF);
      expect_reg(idx[i], exp[i]);
    end
    `CHECK(io_base, 16'h03E0)
    `CHECK(rom_base, 24'h0DC000)
    `CHECK(rom_size, 5'h10)
    i_host.write_reg(IDX_IRQ_LEVEL, 8'h00);
    `CHECK(irq_level, 4'h0)
    i_host.write_reg(IDX_IRQ_LEVEL, 8'hF5);
    expect_reg(IDX_IRQ_LEVEL, 8'h05);
    expect_reg(IDX_IRQ_TYPE, 8'h02);
    expect_reg(IDX_DMA_SELECT_ONE, 8'h04);
    expect_reg(IDX_CONFIG_ONE, 8'hFD);
    $display("masked_writes done");
  endtask : masked_writes
  task automatic select_and_activate();
    i_host.write_reg(IDX_SELECT_NUMBER, 8'h07);
    `CHECK(card, 8'h07)
    expect_reg(IDX_SAVED_SELECT, 8'h07);
    i_host.write_reg(IDX_VENDOR_COMMAND, 8'h04);
    `CHECK(card, 8'h00)
    expect_reg(IDX_SAVED_SELECT, 8'h07);
    i_host.write_reg(IDX_SELECT_NUMBER, 8'h09);
    repeat (3) @(negedge clock);
    `CHECK(card, 8'h09)
    i_host.write_reg(IDX_ACTIVATE, 8'h00);
    `CHECK(active, 1'b0)
    expect_reg(IDX_ACTIVATE, 8'h00);
    i_host.write_reg(IDX_ACTIVATE, 8'h01);
    `CHECK(active, 1'b1)
    @(negedge clock);
    eeprom_load = 1'b1;
    @(negedge clock);
    eeprom_load = 1'b0;
    @(negedge clock);
    `CHECK(io_base, 16'h0300)
    `CHECK(irq_level, 4'h3)
    `CHECK(active, 1'b1)
    $display("select_and_activate done");
  endtask : select_and_activate
  task automatic plug_play_modes();
    power(1'b0, 1'b1, 1'b0);
    `CHECK(mode, plug_play_mode)
    `CHECK(active, 1'b0)
    `CHECK(io_base, 16'h0240)
    i_host.send_key(PLUG_PLAY_KEY, 10);
    `CHECK(config_open, 1'b0)
    i_host.send_key(PLUG_PLAY_KEY, 99);
    `CHECK(config_open, 1'b1)
    expect_reg(IDX_CONFIG_THREE, 8'h81);
    i_host.write_reg(IDX_ACTIVATE, 8'h01);
    `CHECK(active, 1'b1)
    eeprom_io_base = 16'h0280;
    eeprom_irq = 4'h9;
    power(1'b0, 1'b0, 1'b0);
    `CHECK(mode, vendor_jumperless_mode)
    `CHECK(active, 1'b1)
    `CHECK(irq_level, 4'h9)
    power(1'b0, 1'b0, 1'b1);
    `CHECK(mode, plug_play_mode)
    `CHECK(io_base, 16'h0280)
    $display("plug_play_modes done");
  endtask : plug_play_modes
  initial begin
    power(1'b1, 1'b1, 1'b0);
    jumper_keys();
    masked_writes();
    select_and_activate();
    plug_play_modes();
    report_and_stop();
  end
endmodule : pnp_logical_device_config_tb
`default_nettype wire
